// file: verilog/exc_ctl_pkg.sv
package exc_ctl_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_MSW       = 8'h00;
  localparam logic [7:0]  OFS_RET_ADDR  = 8'h04;
  localparam logic [7:0]  OFS_SAVED_MSW = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;

  // ----------------------------------------------------------------
  // machine state word fields, lsb-based index (big-endian bit n is 31-n)
  // ----------------------------------------------------------------
  localparam int          POS_EXC_BYTE_ORDER = 16;  // big-endian bit 15
  localparam int          POS_MCHK_ENABLE    = 12;  // big-endian bit 19
  localparam int          POS_VEC_BASE_HIGH  = 6;   // big-endian bit 25
  localparam int          POS_CUR_BYTE_ORDER = 0;   // big-endian bit 31
  localparam logic [31:0] MSW_IMPL_MASK      = 32'h0205_FF77;
  localparam logic [31:0] MSW_ENTRY_CLR_MASK = 32'h0204_EF36;
  localparam logic [31:0] MSW_RESET          = 32'h0000_0000;

  // saved state word layout
  localparam logic [31:0] SAVED_COPY_MASK    = 32'h0200_FFFF;
  localparam int          POS_INFO_HI        = 26;  // big-endian bits 1..5
  localparam int          POS_INFO_LO        = 16;  // big-endian bits 10..15
  localparam logic [31:0] ADDR_RESET         = 32'h0000_0000;

  // handler base addresses
  localparam logic [31:0] VEC_BASE_LOW       = 32'h0000_0000;
  localparam logic [31:0] VEC_BASE_HIGH      = 32'hFFF0_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        is_mchk;
    logic [19:0] vec_off;
    logic [31:0] ret_addr;
    logic [10:0] info;
  } exc_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } fetch_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DRAIN_RET,
    ST_DRAIN_SYNC,
    ST_DRAIN_CSYNC
  } flow_t;

endpackage

// file: verilog/exception_entry_return_ctl.sv
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps
module exception_entry_return_ctl (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  input  wire exc_ctl_pkg::apb_req_t  i_apb,
  output exc_ctl_pkg::apb_rsp_t       o_apb,
  input  wire exc_ctl_pkg::exc_req_t  i_exc,
  input  wire logic                   i_ret_req,
  input  wire logic                   i_sync_req,
  input  wire logic                   i_csync_req,
  input  wire logic [31:0]            i_next_pc,
  input  wire logic                   i_prior_done,
  input  wire logic                   i_resv_set,
  input  wire logic                   i_cond_store,
  output logic [31:0]                 o_msw,
  output exc_ctl_pkg::fetch_t         o_fetch,
  output logic                        o_flush,
  output logic                        o_hold_issue,
  output logic                        o_barrier_done,
  output logic                        o_reservation,
  output logic                        o_checkstop
);
  import exc_ctl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] msw_reg;
  logic [31:0] msw_next;
  logic [31:0] ret_addr_reg;
  logic [31:0] saved_msw_reg;
  logic [31:0] csync_pc_reg;
  flow_t       flow_reg;
  flow_t       flow_next;
  logic        resv_reg;
  logic        chkstop_reg;
  fetch_t      fetch_reg;
  logic        flush_reg;
  logic        hold_reg;
  logic        bdone_reg;
  apb_rsp_t    apb_reg;

  logic        take_exc;
  logic        abort;
  logic        enter_chkstop;
  logic        do_return;
  logic        do_sync_done;
  logic        do_csync_done;
  logic        apb_setup;
  logic        apb_wr;
  logic [31:0] entry_msw;
  logic [31:0] entry_saved;
  logic [31:0] vec_addr;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // reserved bits forced to zero on every store into the machine state word
  function automatic logic [31:0] impl_only(input logic [31:0] v);
    impl_only = v & MSW_IMPL_MASK;
  endfunction

  // known register offsets
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == OFS_MSW) || (a == OFS_RET_ADDR) ||
               (a == OFS_SAVED_MSW) || (a == OFS_STATUS);
  endfunction

  // a return or barrier is in flight
  function automatic logic is_busy(input flow_t s);
    is_busy = (s != ST_IDLE);
  endfunction

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  // machine check with checking disabled stops the core instead
  assign enter_chkstop = i_exc.valid && i_exc.is_mchk && !msw_reg[POS_MCHK_ENABLE] &&
                         !chkstop_reg;
  assign take_exc      = i_exc.valid && !enter_chkstop && !chkstop_reg;
  // entry, or a machine check that stops the core, drops a pending return
  assign abort         = take_exc || enter_chkstop || chkstop_reg;
  // completion waits for the older instructions to drain
  assign do_return     = (flow_reg == ST_DRAIN_RET) && i_prior_done && !abort;
  assign do_sync_done  = (flow_reg == ST_DRAIN_SYNC) && i_prior_done && !abort;
  assign do_csync_done = (flow_reg == ST_DRAIN_CSYNC) && i_prior_done && !abort;
  assign apb_setup     = i_apb.psel && !i_apb.penable;
  assign apb_wr        = i_apb.psel && i_apb.penable && i_apb.pwrite && apb_reg.pready;

  // ----------------------------------------------------------------
  // entry values
  // ----------------------------------------------------------------
  always_comb begin
    entry_msw = msw_reg & ~MSW_ENTRY_CLR_MASK;
    // bits 15 and 25 fall through untouched
    entry_msw[POS_EXC_BYTE_ORDER] = msw_reg[POS_EXC_BYTE_ORDER];
    entry_msw[POS_VEC_BASE_HIGH]  = msw_reg[POS_VEC_BASE_HIGH];
    entry_msw[POS_MCHK_ENABLE]    = i_exc.is_mchk ? 1'b0 : msw_reg[POS_MCHK_ENABLE];
    entry_msw[POS_CUR_BYTE_ORDER] = msw_reg[POS_EXC_BYTE_ORDER];
    entry_msw = impl_only(entry_msw);
  end

  // saved word: copy region, info fields, zeros elsewhere
  always_comb begin
    entry_saved = msw_reg & SAVED_COPY_MASK;
    entry_saved[POS_INFO_HI +: 5] = i_exc.info[10:6];
    entry_saved[POS_INFO_LO +: 6] = i_exc.info[5:0];
  end

  // handler address from the prefix bit
  always_comb begin
    vec_addr = (msw_reg[POS_VEC_BASE_HIGH] ? VEC_BASE_HIGH : VEC_BASE_LOW) |
               {12'h000, i_exc.vec_off};
  end

  // ----------------------------------------------------------------
  // machine state word: one write per cycle, hardware over software
  // ----------------------------------------------------------------
  always_comb begin
    msw_next = msw_reg;
    if (take_exc) begin
      msw_next = entry_msw;
    end else if (do_return) begin
      msw_next = impl_only(saved_msw_reg);
    end else if (apb_wr && i_apb.paddr == OFS_MSW) begin
      msw_next = impl_only(i_apb.pwdata);
    end
  end

  // the whole word changes at one edge, so no instruction ever sees a
  // half-applied entry or restore
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      msw_reg <= MSW_RESET;
    end else begin
      msw_reg <= msw_next;
    end
  end

  // saved return address and saved state word
  // software preloads both before a return; stored raw, masked on restore
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ret_addr_reg  <= ADDR_RESET;
      saved_msw_reg <= MSW_RESET;
    end else if (take_exc) begin
      ret_addr_reg  <= i_exc.ret_addr;
      saved_msw_reg <= entry_saved;
    end else if (apb_wr) begin
      if (i_apb.paddr == OFS_RET_ADDR) begin
        ret_addr_reg <= i_apb.pwdata;
      end
      if (i_apb.paddr == OFS_SAVED_MSW) begin
        saved_msw_reg <= i_apb.pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // barrier / return sequencing
  // ----------------------------------------------------------------
  always_comb begin
    flow_next = flow_reg;
    case (flow_reg)
      ST_IDLE: begin
        if (i_ret_req) begin
          flow_next = ST_DRAIN_RET;
        end else if (i_sync_req) begin
          flow_next = ST_DRAIN_SYNC;
        end else if (i_csync_req) begin
          flow_next = ST_DRAIN_CSYNC;
        end
      end
      ST_DRAIN_RET: begin
        if (i_prior_done) begin
          flow_next = ST_IDLE;
        end
      end
      ST_DRAIN_SYNC: begin
        if (i_prior_done) begin
          flow_next = ST_IDLE;
        end
      end
      ST_DRAIN_CSYNC: begin
        if (i_prior_done) begin
          flow_next = ST_IDLE;
        end
      end
      default: begin
        flow_next = ST_IDLE;
      end
    endcase
    // an exception, or a machine check that stops the core, abandons
    // any pending barrier or return
    if (abort) begin
      flow_next = ST_IDLE;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flow_reg <= ST_IDLE;
    end else begin
      flow_reg <= flow_next;
    end
  end

  // refetch point of the context barrier
  // taken from idle when no return or sync request is seen, even if an abort drops it; requests while busy are ignored
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      csync_pc_reg <= ADDR_RESET;
    end else if (flow_reg == ST_IDLE && i_csync_req && !i_ret_req && !i_sync_req) begin
      csync_pc_reg <= i_next_pc;
    end
  end

  // later issue is held while older work drains under the old context;
  // taken from the next state so issue stops at the accepting edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= is_busy(flow_next);
    end
  end

  // ----------------------------------------------------------------
  // fetch redirect, flush and barrier completion
  // ----------------------------------------------------------------
  // redirect lands in the same edge as the new state word
  // entry and completion exclude each other, so one cause at most
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fetch_reg <= '0;
      flush_reg <= 1'b0;
    end else begin
      fetch_reg.valid <= take_exc || do_return || do_csync_done;
      flush_reg       <= take_exc || do_return || do_csync_done;
      if (take_exc) begin
        fetch_reg.addr <= vec_addr;
      end else if (do_return) begin
        fetch_reg.addr <= ret_addr_reg;
      end else if (do_csync_done) begin
        fetch_reg.addr <= csync_pc_reg;
      end
    end
  end

  // one-cycle completion pulse for either barrier
  // a return reports through the redirect instead
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bdone_reg <= 1'b0;
    end else begin
      bdone_reg <= do_sync_done || do_csync_done;
    end
  end

  // ----------------------------------------------------------------
  // reservation and checkstop
  // ----------------------------------------------------------------
  // exceptions leave the reservation alone; stream prefetch is not touched here
  // a reserving load in the same cycle as a conditional store wins
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resv_reg <= 1'b0;
    end else if (i_resv_set) begin
      resv_reg <= 1'b1;
    end else if (i_cond_store) begin
      resv_reg <= 1'b0;
    end
  end

  // sticky until reset
  // once stopped, later exceptions and requests are ignored
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chkstop_reg <= 1'b0;
    end else if (enter_chkstop) begin
      chkstop_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: one wait-free access phase
  // ----------------------------------------------------------------
  // pready answers the setup cycle, so the access phase never waits;
  // a state word read returns the value that holds after that edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      apb_reg <= '0;
    end else begin
      apb_reg.pready  <= apb_setup;
      apb_reg.pslverr <= apb_setup && !addr_hit(i_apb.paddr);
      apb_reg.prdata  <= 32'h0000_0000;
      if (apb_setup && !i_apb.pwrite) begin
        case (i_apb.paddr)
          OFS_MSW:       apb_reg.prdata <= msw_next;
          OFS_RET_ADDR:  apb_reg.prdata <= ret_addr_reg;
          OFS_SAVED_MSW: apb_reg.prdata <= saved_msw_reg;
          OFS_STATUS:    apb_reg.prdata <= {28'h000_0000, hold_reg, chkstop_reg,
                                            resv_reg, is_busy(flow_reg)};
          default:       apb_reg.prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a register; no logic after the flip-flops
  assign o_apb          = apb_reg;
  assign o_msw          = msw_reg;
  assign o_fetch        = fetch_reg;
  assign o_flush        = flush_reg;
  assign o_hold_issue   = hold_reg;
  assign o_barrier_done = bdone_reg;
  assign o_reservation  = resv_reg;
  assign o_checkstop    = chkstop_reg;

endmodule

// file: testbench/exc_ctl_sva.sv
`timescale 1ns/10ps
module exc_ctl_sva
  import exc_ctl_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire apb_req_t    i_apb,
  input wire apb_rsp_t    o_apb,
  input wire exc_req_t    i_exc,
  input wire logic        i_ret_req,
  input wire logic        i_sync_req,
  input wire logic        i_csync_req,
  input wire logic [31:0] i_next_pc,
  input wire logic        i_prior_done,
  input wire logic        i_resv_set,
  input wire logic        i_cond_store,
  input wire logic [31:0] o_msw,
  input wire fetch_t      o_fetch,
  input wire logic        o_flush,
  input wire logic        o_hold_issue,
  input wire logic        o_barrier_done,
  input wire logic        o_reservation,
  input wire logic        o_checkstop
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  // ----------------
  // sequences
  // ----------------
  sequence s_entry;
    i_exc.valid && !o_checkstop && (!i_exc.is_mchk || o_msw[POS_MCHK_ENABLE]);
  endsequence
  sequence s_drain_end;
    o_hold_issue && i_prior_done && !i_exc.valid;
  endsequence
  // ----------------
  // assertions
  // ----------------
  entry_clear_a: assert property (s_entry |=> (o_msw & MSW_ENTRY_CLR_MASK) == 0)
    else $error("entry left bits set");
  byte_order_a: assert property (s_entry |=> o_msw[0] == $past(o_msw[16])
    && $stable(o_msw[16]) && $stable(o_msw[6])) else $error("byte order or prefix wrong");
  mchk_keep_a: assert property (s_entry |=>
    o_msw[12] == ($past(o_msw[12]) && !$past(i_exc.is_mchk))) else $error("check enable bit wrong");
  vec_base_a: assert property (s_entry |=> o_fetch.valid && o_fetch.addr ==
    ((o_msw[6] ? VEC_BASE_HIGH : VEC_BASE_LOW) | {12'h000, $past(i_exc.vec_off)}))
    else $error("handler address wrong");
  rsvd_zero_a: assert property ((o_msw & ~MSW_IMPL_MASK) == 0)
    else $error("reserved bit set");
  drain_wait_a: assert property (o_hold_issue && !i_prior_done && !i_exc.valid |=>
    o_hold_issue && !o_fetch.valid && !o_barrier_done) else $error("drain ended early");
  drain_end_a: assert property (s_drain_end |=>
    !o_hold_issue && (o_fetch.valid || o_barrier_done)) else $error("drain not ended");
  accept_a: assert property ((i_ret_req || i_sync_req || i_csync_req) && !o_hold_issue
    && !i_exc.valid && !o_checkstop |=> o_hold_issue) else $error("issue not held");
  flush_pair_a: assert property (o_flush == o_fetch.valid)
    else $error("flush without redirect");
  resv_clear_a: assert property (i_cond_store && !i_resv_set |=> !o_reservation)
    else $error("reservation kept");
endmodule

bind exception_entry_return_ctl exc_ctl_sva u_sva (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_apb(i_apb), .o_apb(o_apb), .i_exc(i_exc),
  .i_ret_req(i_ret_req), .i_sync_req(i_sync_req), .i_csync_req(i_csync_req),
  .i_next_pc(i_next_pc), .i_prior_done(i_prior_done), .i_resv_set(i_resv_set),
  .i_cond_store(i_cond_store), .o_msw(o_msw), .o_fetch(o_fetch), .o_flush(o_flush),
  .o_hold_issue(o_hold_issue), .o_barrier_done(o_barrier_done),
  .o_reservation(o_reservation), .o_checkstop(o_checkstop));

// file: testbench/exception_entry_return_ctl_tb.sv
`timescale 1ns/10ps
module exception_entry_return_ctl_tb;
  import exc_ctl_pkg::*;
  logic        mclk, rst_n, ret, sync, csync, prior, rset, cst;
  logic        flush, hold, bdone, resv, cstop;
  logic [31:0] npc, msw, m;
  apb_req_t    apb;
  apb_rsp_t    rsp;
  exc_req_t    exc;
  fetch_t      fch;
  int          fails, num_checks;

  exception_entry_return_ctl dut (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_apb(apb), .o_apb(rsp), .i_exc(exc),
    .i_ret_req(ret), .i_sync_req(sync), .i_csync_req(csync), .i_next_pc(npc),
    .i_prior_done(prior), .i_resv_set(rset), .i_cond_store(cst), .o_msw(msw),
    .o_fetch(fch), .o_flush(flush), .o_hold_issue(hold), .o_barrier_done(bdone),
    .o_reservation(resv), .o_checkstop(cstop));

  // ----------------
  // helpers
  // ----------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // apb transfer: setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    @(posedge mclk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge mclk);
    apb.penable <= 1'b1;
    @(posedge mclk);
    while (rsp.pready !== 1'b1) @(posedge mclk);
    rd = rsp.prdata;
    er = rsp.pslverr;
    apb <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        er;
    xfer(1'b1, a, v, d, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic        er;
    xfer(1'b0, a, 32'h0000_0000, d, er);
    chk(d, e);
    chk(er, 1'b0);
  endtask

  task automatic take_exc(input logic mc, input logic [19:0] off, input logic [10:0] inf);
    @(posedge mclk);
    exc <= '{valid: 1'b1, is_mchk: mc, vec_off: off, ret_addr: 32'h1234_5678, info: inf};
    @(posedge mclk);
    exc.valid <= 1'b0;
    @(negedge mclk);
  endtask

  // expected state word after entry, from the cleared bit list
  function automatic logic [31:0] entry_val(input logic [31:0] v, input logic mc);
    int          clr [13] = '{6, 13, 16, 17, 18, 20, 21, 22, 23, 26, 27, 29, 30};
    logic [31:0] r;
    r = v;
    foreach (clr[i]) r[31 - clr[i]] = 1'b0;
    if (mc) r[12] = 1'b0;
    r[0] = v[16];
    return r;
  endfunction

  // ----------------
  // clock, watchdog
  // ----------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end

  // ----------------
  // tests
  // ----------------
  initial begin
    logic [31:0] d;
    logic        er;
    {rst_n, ret, sync, csync, prior, rset, cst} = '0;
    apb = '0;
    exc = '0;
    npc = '0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd_chk(8'(4 * i), 32'h0000_0000);
    $display("reset test done");
    wr(OFS_MSW, 32'hFFFF_FFFF);
    rd_chk(OFS_MSW, 32'h0205_FF77);
    xfer(1'b1, 8'h10, 32'hFFFF_FFFF, d, er);
    chk(er, 1'b1);
    xfer(1'b0, 8'h10, 32'h0000_0000, d, er);
    chk({d[30:0], er}, 32'h0000_0001);
    $display("register test done");
    m = msw;
    take_exc(1'b0, 20'h0_0700, 11'h5A5);
    chk(msw, entry_val(m, 1'b0));
    chk({fch.valid, flush}, 2'b11);
    chk(fch.addr, 32'hFFF0_0700);
    rd_chk(OFS_RET_ADDR, 32'h1234_5678);
    rd_chk(OFS_SAVED_MSW, {1'b0, 5'b10110, m[25], 3'b000, 6'b100101, m[15:0]});
    wr(OFS_MSW, 32'h0000_1001);
    take_exc(1'b1, 20'h0_0200, 11'h7FF);
    chk(msw, 32'h0000_0000);
    chk(fch.addr, 32'h0000_0200);
    rd_chk(OFS_SAVED_MSW, {1'b0, 5'b11111, 1'b0, 3'b000, 6'h3F, 16'h1001});
    $display("entry test done");
    wr(OFS_SAVED_MSW, 32'hFFFF_FFFF);
    wr(OFS_RET_ADDR, 32'h0000_3000);
    @(posedge mclk) ret <= 1'b1;
    @(posedge mclk) ret <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({hold, fch.valid, msw[0]}, 3'b100);
    @(posedge mclk) prior <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk(msw, 32'h0205_FF77);
    chk({fch.valid, flush, hold}, 3'b110);
    chk(fch.addr, 32'h0000_3000);
    $display("return test done");
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) begin
        prior <= 1'b0;
        npc <= 32'h0000_4440;
        if (k == 1) csync <= 1'b1;
        else sync <= 1'b1;
      end
      @(posedge mclk) {sync, csync} <= 2'b00;
      @(negedge mclk) chk({hold, bdone}, 2'b10);
      @(posedge mclk) prior <= 1'b1;
      @(posedge mclk);
      @(negedge mclk) chk({bdone, hold, flush}, {2'b10, k[0]});
      if (k == 1) chk(fch.addr, 32'h0000_4440);
    end
    $display("barrier test done");
    @(posedge mclk) rset <= 1'b1;
    @(posedge mclk) rset <= 1'b0;
    @(negedge mclk) chk(resv, 1'b1);
    @(posedge mclk) cst <= 1'b1;
    @(posedge mclk) cst <= 1'b0;
    @(negedge mclk) chk(resv, 1'b0);
    $display("reservation test done");
    wr(OFS_MSW, 32'h0000_0000);
    take_exc(1'b1, 20'h0_0200, 11'h000);
    chk({cstop, fch.valid, msw[12]}, 3'b100);
    take_exc(1'b0, 20'h0_0300, 11'h000);
    chk(fch.valid, 1'b0);
    $display("checkstop test done");
    tally_and_finish();
  end
endmodule
